// File: core/cimf_pkg.sv
// Constants, field indices and carrier types for the CPU interrupt mode and flag logic.
package cimf_pkg;

  localparam int unsigned NUM_CPU   = 8;
  localparam int unsigned CPU_W     = 3;
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned CHAN_W    = 7;
  localparam int unsigned NUM_FLAGS = 8;

  localparam logic [CHAN_W-1:0]    MAINT_CHANNEL = 7'h28;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET   = 8'h00;
  localparam logic [1:0]           RST_SYNC_INIT = 2'h0;

  localparam int unsigned FLG_IO   = 0;
  localparam int unsigned FLG_OPND = 1;
  localparam int unsigned FLG_PCI  = 2;
  localparam int unsigned FLG_PRE  = 3;
  localparam int unsigned FLG_RPE  = 4;
  localparam int unsigned FLG_RTC  = 5;
  localparam int unsigned FLG_UMEM = 6;
  localparam int unsigned FLG_MCU  = 7;

  typedef struct packed {
    logic monitor_state_bit;
    logic maintenance_interrupt_enable;
    logic uncorrectable_memory_interrupt_enable;
    logic realtime_clock_interrupt_enable;
    logic register_parity_interrupt_enable;
    logic program_range_interrupt_enable;
    logic progclock_interrupt_enable;
    logic operand_range_interrupt_enable;
    logic io_interrupt_enable;
  } cimf_modes_t;

  typedef struct packed {
    logic              low_speed_channel_done;
    logic              very_high_speed_channel_done;
    logic              data_ref_valid;
    logic [ADDR_W-1:0] data_ref_addr;
    logic              program_range_error;
    logic              register_parity_error;
    logic              progclock_count_zero;
    logic              realtime_clock_request;
    logic              memory_read;
    logic              memory_uncorrectable;
  } cimf_events_t;

  typedef struct packed {
    logic              active;
    logic [CHAN_W-1:0] channel;
    logic [CPU_W-1:0]  target_cpu;
  } cimf_maint_t;

endpackage : cimf_pkg

// File: core/cimf_flag_bank.sv
// Bank of sticky interrupt flags where a set in the clearing cycle wins.
module cimf_flag_bank (
  input  wire logic                           clk_i,
  input  wire logic                           rst_n_i,
  input  wire logic [cimf_pkg::NUM_FLAGS-1:0] set_i,
  input  wire logic [cimf_pkg::NUM_FLAGS-1:0] clear_i,
  output logic      [cimf_pkg::NUM_FLAGS-1:0] flags_o
);

  logic [cimf_pkg::NUM_FLAGS-1:0] flag_d;
  logic [cimf_pkg::NUM_FLAGS-1:0] flag_q;

  for (genvar i = 0; i < cimf_pkg::NUM_FLAGS; i++) begin : g_flag
    // A set arriving with the clear keeps the flag, so no event is lost.
    assign flag_d[i] = set_i[i] | (flag_q[i] & ~clear_i[i]);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_q <= cimf_pkg::FLAGS_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flags_o = flag_q;

endmodule // cimf_flag_bank

// File: core/cimf_intr_logic.sv
// Per-CPU interrupt qualification: mode gating, flag setting and request merge.
module cimf_intr_logic (
  input  wire logic                           sys_clk_i,
  input  wire logic                           nrst_i,
  input  wire logic [cimf_pkg::CPU_W-1:0]     cpu_number_i,
  input  wire cimf_pkg::cimf_modes_t          modes_i,
  input  wire logic                           system_interrupt_enable_i,
  input  wire logic                           interrupts_enabled_i,
  input  wire logic [cimf_pkg::NUM_CPU-1:0]   io_ready_cpus_i,
  input  wire logic [cimf_pkg::ADDR_W-1:0]    data_base_address_i,
  input  wire logic [cimf_pkg::ADDR_W-1:0]    data_limit_address_i,
  input  wire cimf_pkg::cimf_events_t         events_i,
  input  wire cimf_pkg::cimf_maint_t          maint_i,
  input  wire logic [cimf_pkg::NUM_FLAGS-1:0] flag_clear_i,
  output logic                                io_ready_o,
  output logic      [cimf_pkg::NUM_FLAGS-1:0] flags_o,
  output logic                                irq_o
);

  logic [1:0]                     rst_sync_q;
  logic                           rst_n;
  logic [cimf_pkg::NUM_CPU:0]     below;
  logic                           lowest_io_cpu;
  logic                           channel_done;
  logic                           out_of_range;
  logic                           maint_hit;
  logic                           maint_d;
  logic                           maint_q;
  logic                           irq_d;
  logic                           irq_q;
  logic                           gate;
  logic [cimf_pkg::NUM_FLAGS-1:0] set_vec;

  // Reset is released through two flops so every flop behind rst_n leaves reset on one edge.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= cimf_pkg::RST_SYNC_INIT;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Own readiness for I/O interrupts; other CPUs see it on io_ready_o.
  assign io_ready_o = modes_i.io_interrupt_enable & interrupts_enabled_i;

  // Running OR of readiness below each CPU index picks the lowest ready CPU.
  assign below[0] = 1'b0;
  for (genvar c = 0; c < cimf_pkg::NUM_CPU; c++) begin : g_lowest
    assign below[c+1] = below[c] | io_ready_cpus_i[c];
  end
  assign lowest_io_cpu = io_ready_o & ~below[cpu_number_i];

  assign channel_done = events_i.low_speed_channel_done
                      | events_i.very_high_speed_channel_done;

  assign out_of_range = events_i.data_ref_valid
                      & ((events_i.data_ref_addr < data_base_address_i)
                      |  (events_i.data_ref_addr >= data_limit_address_i));

  assign maint_hit = maint_i.active
                   & (maint_i.channel == cimf_pkg::MAINT_CHANNEL)
                   & (maint_i.target_cpu == cpu_number_i);

  // Monitor mode holds back every event except memory errors.
  assign gate = ~modes_i.monitor_state_bit;

  always_comb begin
    set_vec = '0;
    set_vec[cimf_pkg::FLG_IO]  = channel_done & system_interrupt_enable_i
                               & lowest_io_cpu & gate;
    set_vec[cimf_pkg::FLG_OPND] = out_of_range
                                & modes_i.operand_range_interrupt_enable & gate;
    set_vec[cimf_pkg::FLG_PCI] = events_i.progclock_count_zero
                               & modes_i.progclock_interrupt_enable
                               & interrupts_enabled_i & gate;
    set_vec[cimf_pkg::FLG_PRE] = events_i.program_range_error
                               & modes_i.program_range_interrupt_enable & gate;
    set_vec[cimf_pkg::FLG_RPE] = events_i.register_parity_error
                               & modes_i.register_parity_interrupt_enable & gate;
    set_vec[cimf_pkg::FLG_RTC] = events_i.realtime_clock_request
                               & modes_i.realtime_clock_interrupt_enable & gate;
    set_vec[cimf_pkg::FLG_UMEM] = events_i.memory_read & events_i.memory_uncorrectable
                                & modes_i.uncorrectable_memory_interrupt_enable
                                & interrupts_enabled_i;
    set_vec[cimf_pkg::FLG_MCU] = maint_hit & ~maint_q
                               & modes_i.maintenance_interrupt_enable
                               & interrupts_enabled_i & gate;
  end

  always_comb begin
    maint_d = maint_hit;
    irq_d   = |flags_o;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      maint_q <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      maint_q <= maint_d;
      irq_q   <= irq_d;
    end
  end

  assign irq_o = irq_q;

  cimf_flag_bank u_flags (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n),
    .set_i   (set_vec),
    .clear_i (flag_clear_i),
    .flags_o (flags_o)
  );

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  io_flag_set_a: assert property (
    channel_done && system_interrupt_enable_i && io_ready_o && !below[cpu_number_i]
      && !modes_i.monitor_state_bit |=> flags_o[cimf_pkg::FLG_IO])
    else $error("I/O flag did not set for lowest ready CPU");

  io_flag_lower_a: assert property (
    !flags_o[cimf_pkg::FLG_IO] && below[cpu_number_i] |=> !flags_o[cimf_pkg::FLG_IO])
    else $error("I/O flag set although a lower CPU was ready");

  opnd_flag_set_a: assert property (
    out_of_range && modes_i.operand_range_interrupt_enable && !modes_i.monitor_state_bit
      |=> flags_o[cimf_pkg::FLG_OPND])
    else $error("Operand range flag did not set");

  pre_flag_hold_a: assert property (
    !modes_i.program_range_interrupt_enable && !flags_o[cimf_pkg::FLG_PRE]
      |=> !flags_o[cimf_pkg::FLG_PRE])
    else $error("Program range flag set with mode bit clear");

  pci_flag_set_a: assert property (
    events_i.progclock_count_zero && modes_i.progclock_interrupt_enable
      && interrupts_enabled_i && gate |=> flags_o[cimf_pkg::FLG_PCI])
    else $error("Programmable clock flag did not set");

  rtc_ignore_a: assert property (
    !modes_i.realtime_clock_interrupt_enable && !flags_o[cimf_pkg::FLG_RTC]
      |=> !flags_o[cimf_pkg::FLG_RTC])
    else $error("Real-time clock flag set with mode bit clear");

  umem_monitor_a: assert property (
    modes_i.monitor_state_bit && events_i.memory_read && events_i.memory_uncorrectable
      && modes_i.uncorrectable_memory_interrupt_enable && interrupts_enabled_i
      |=> flags_o[cimf_pkg::FLG_UMEM])
    else $error("Uncorrectable memory flag blocked in monitor mode");

  monitor_block_a: assert property (
    modes_i.monitor_state_bit && !flags_o[cimf_pkg::FLG_RPE]
      |=> !flags_o[cimf_pkg::FLG_RPE])
    else $error("Parity flag set in monitor mode");

  mcu_edge_a: assert property (
    maint_hit && !flags_o[cimf_pkg::FLG_MCU] ##1 maint_hit && !flag_clear_i[cimf_pkg::FLG_MCU]
      ##1 flag_clear_i[cimf_pkg::FLG_MCU] && maint_hit |=> !flags_o[cimf_pkg::FLG_MCU])
    else $error("Maintenance flag set on a held level");

  flag_sticky_a: assert property (
    ##1 (($past(flags_o) & ~$past(flag_clear_i) & ~flags_o) == '0))
    else $error("A flag dropped without a clear");

  irq_merge_a: assert property (
    (|flags_o) |=> irq_o ##0 ((|$past(flags_o)) == irq_o))
    else $error("Interrupt request does not follow the flags");

  irq_idle_a: assert property (
    !(|flags_o) |=> !irq_o)
    else $error("Interrupt request raised with no flag set");

  // A clear mode bit must leave its flag alone, and a set one must let the event land.
  opnd_ignore_a: assert property (
    !modes_i.operand_range_interrupt_enable && !flags_o[cimf_pkg::FLG_OPND]
      |=> !flags_o[cimf_pkg::FLG_OPND])
    else $error("Operand range flag set with mode bit clear");

  pci_ignore_a: assert property (
    !modes_i.progclock_interrupt_enable && !flags_o[cimf_pkg::FLG_PCI]
      |=> !flags_o[cimf_pkg::FLG_PCI])
    else $error("Programmable clock flag set with mode bit clear");

  pre_flag_set_a: assert property (
    events_i.program_range_error && modes_i.program_range_interrupt_enable
      && !modes_i.monitor_state_bit |=> flags_o[cimf_pkg::FLG_PRE])
    else $error("Program range flag did not set");

  rpe_flag_set_a: assert property (
    events_i.register_parity_error && modes_i.register_parity_interrupt_enable
      && !modes_i.monitor_state_bit |=> flags_o[cimf_pkg::FLG_RPE])
    else $error("Register parity flag did not set");

  rtc_flag_set_a: assert property (
    events_i.realtime_clock_request && modes_i.realtime_clock_interrupt_enable
      && !modes_i.monitor_state_bit |=> flags_o[cimf_pkg::FLG_RTC])
    else $error("Real-time clock flag did not set");

  umem_ignore_a: assert property (
    !modes_i.uncorrectable_memory_interrupt_enable && !flags_o[cimf_pkg::FLG_UMEM]
      |=> !flags_o[cimf_pkg::FLG_UMEM])
    else $error("Uncorrectable memory flag set with mode bit clear");

  mcu_target_a: assert property (
    (maint_i.target_cpu != cpu_number_i) && !flags_o[cimf_pkg::FLG_MCU]
      |=> !flags_o[cimf_pkg::FLG_MCU])
    else $error("Maintenance flag set for another CPU");

  flag_clear_a: assert property (
    (|flag_clear_i) |=> ((flags_o & $past(flag_clear_i) & ~$past(set_vec)) == '0))
    else $error("A cleared flag stayed set");

  io_cover_c:    cover property (channel_done && set_vec[cimf_pkg::FLG_IO]);
  mcu_cover_c:   cover property (set_vec[cimf_pkg::FLG_MCU] ##1 irq_o);
  clash_cover_c: cover property (|(set_vec & flag_clear_i));
  mon_cover_c:   cover property (modes_i.monitor_state_bit && set_vec[cimf_pkg::FLG_UMEM]);
  rpe_block_c:   cover property (modes_i.monitor_state_bit && events_i.register_parity_error);

endmodule // cimf_intr_logic

// File: tb/cimf_exch_model.sv
// Behavioural model of the exchange logic that clears flags after an interrupt request.
module cimf_exch_model (
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic [3:0] wait_i,
  input  wire logic       irq_i,
  input  wire logic [7:0] flags_i,
  output logic      [7:0] clear_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic       hit;
  initial begin
    clear_o = 8'h00;
    cnt     = 4'h0;
    hit     = 1'b0;
  end
  // The wait is counted on the rising edge, where the bench's enable has settled.
  always @(posedge clk_i) begin
    if (en_i && irq_i && cnt == wait_i) begin
      hit <= 1'b1;
      cnt <= 4'h0;
    end else begin
      hit <= 1'b0;
      cnt <= (en_i && irq_i) ? cnt + 4'h1 : 4'h0;
    end
  end
  // The clear mask changes on the falling edge so the design samples a settled value.
  always @(negedge clk_i) begin
    clear_o <= hit ? flags_i : 8'h00;
  end
endmodule // cimf_exch_model

// File: tb/testbench.sv
// Self-checking bench for the CPU interrupt mode and flag logic.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   sys_clk, nrst, sys_ie, ien, x_en, io_rdy, irq;
  logic [3:0]             x_wait;
  logic [8:0]             mv;
  cimf_pkg::cimf_events_t ev;
  cimf_pkg::cimf_maint_t  mt;
  logic [7:0]             rdy, x_clr, t_clr, flags, exp;
  logic [31:0]            adr;
  logic [6:0]             mch;
  logic [2:0]             mtg;
  int                     n_mismatch, cmp_count;

  cimf_intr_logic i_cimf_intr_logic (.sys_clk_i(sys_clk), .nrst_i(nrst), .cpu_number_i(3'h2),
    .modes_i(cimf_pkg::cimf_modes_t'(mv)), .system_interrupt_enable_i(sys_ie),
    .interrupts_enabled_i(ien), .io_ready_cpus_i(rdy), .data_base_address_i(32'h100),
    .data_limit_address_i(32'h200), .events_i(ev), .maint_i(mt), .flag_clear_i(x_clr | t_clr),
    .io_ready_o(io_rdy), .flags_o(flags), .irq_o(irq));
  cimf_exch_model i_cimf_exch_model (.clk_i(sys_clk), .en_i(x_en), .wait_i(x_wait),
    .irq_i(irq), .flags_i(flags), .clear_o(x_clr));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // One event pulse; returns on the falling edge after the sampling edge.
  task automatic fire(input int i);
    @(negedge sys_clk);
    case (i)
      0: ev.low_speed_channel_done = 1'b1;
      1: {ev.data_ref_valid, ev.data_ref_addr} = {1'b1, adr};
      2: ev.progclock_count_zero = 1'b1;
      3: ev.program_range_error = 1'b1;
      4: ev.register_parity_error = 1'b1;
      5: ev.realtime_clock_request = 1'b1;
      6: {ev.memory_read, ev.memory_uncorrectable} = 2'h3;
      default: mt = '{1'b1, mch, mtg};
    endcase
    @(negedge sys_clk);
    ev = '0;
    mt.active = 1'b0;
  endtask

  // The exchange model clears everything; the wait is bounded.
  task automatic clr_all();
    int k;
    x_en = 1'b1;
    for (k = 0; k < 20 && flags !== 8'h00; k++) @(negedge sys_clk);
    x_en = 1'b0;
    if (k == 20) begin
      n_mismatch++;
      print_verdict();
    end
    @(negedge sys_clk);
    chk({7'h0, irq}, 8'h00);
  endtask

  task automatic try(input int i, input logic [7:0] want);
    fire(i);
    chk(flags, want);
    clr_all();
  endtask

  initial begin
    {nrst, sys_ie, ien, x_en, x_wait, mv, ev, mt, rdy, t_clr} = '0;
    {sys_ie, ien, rdy, adr, mch, mtg} = {2'h3, 8'h04, 32'h200, cimf_pkg::MAINT_CHANNEL, 3'h2};
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(flags, 8'h00);
    for (int i = 0; i < 8; i++) begin
      for (int m = 0; m < 3; m++) begin
        mv = (m == 0) ? 9'(1 << i) : (m == 1) ? (9'h0ff ^ 9'(1 << i)) : 9'h1ff;
        rdy = mv[0] ? 8'h04 : 8'h00;
        exp = (mv[i] && (!mv[8] || i == 6)) ? 8'(1 << i) : 8'h00;
        fire(i);
        chk(flags, exp);
        chk({7'h0, io_rdy}, {7'h0, mv[0] & ien});
        @(negedge sys_clk);
        chk({7'h0, irq}, {7'h0, |exp});
        x_wait = 4'(3 * m);
        clr_all();
      end
    end
    mv = 9'h0ff;
    sys_ie = 1'b0;
    try(0, 8'h00);
    sys_ie = 1'b1;
    rdy = 8'h06;
    try(0, 8'h00);
    rdy = 8'h0c;
    try(0, 8'h01);
    ien = 1'b0;
    try(0, 8'h00);
    chk({7'h0, io_rdy}, 8'h00);
    try(2, 8'h00);
    try(6, 8'h00);
    try(7, 8'h00);
    try(1, 8'h02);
    ien = 1'b1;
    adr = 32'h1ff;
    try(1, 8'h00);
    adr = 32'h100;
    try(1, 8'h00);
    adr = 32'hff;
    try(1, 8'h02);
    mch = 7'h27;
    try(7, 8'h00);
    mch = cimf_pkg::MAINT_CHANNEL;
    mtg = 3'h5;
    try(7, 8'h00);
    mtg = 3'h2;
    t_clr = 8'h04;
    fire(2);
    t_clr = 8'h00;
    chk(flags, 8'h04);
    fire(3);
    repeat (5) @(negedge sys_clk);
    chk(flags, 8'h0c);
    t_clr = 8'h04;
    @(negedge sys_clk);
    t_clr = 8'h00;
    chk(flags, 8'h08);
    chk({7'h0, irq}, 8'h01);
    nrst = 1'b0;
    #1;
    chk(flags, 8'h00);
    @(negedge sys_clk);
    nrst = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk({7'h0, irq}, 8'h00);
    print_verdict();
  end
endmodule // testbench
